// file: src/pas_core.sv
// Auto-shutdown, auto-restart and polarity control of a four-pin PWM
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Automatic restart only when bit 7 of the dead-band register is set.
// - With restart on, flag follows the cause and clears when it goes.
// - With restart off, flag stays set until software clears it.
// - After the flag clears, output resumes only at the next period start.
// - Software writes to the flag are ignored while a cause is active.
// - Comparator shutdown is a level; flag holds while comparator asserts.
// - Writing one to the flag forces shutdown like a hardware source.
// - Two low control bits pick polarity for pairs A/C and B/D.
// - Period timer flag sets as the second period begins.
// - After reset all PWM pins are undriven until software enables them.
module pas_core import pas_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic cmp_shutdown,
    input wire logic pin_shutdown,
    output logic pwm_out_a,
    output logic pwm_out_a_oe,
    output logic pwm_out_b,
    output logic pwm_out_b_oe,
    output logic pwm_out_c,
    output logic pwm_out_c_oe,
    output logic pwm_out_d,
    output logic pwm_out_d_oe,
    output logic irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] pol;
        logic en;
        logic restart;
        logic [1:0] src;
        logic [1:0] lvl;
        logic flag;
        logic [7:0] per;
        logic [7:0] duty;
        logic [3:0] oe;
        logic [1:0] ist;
        logic [1:0] imsk;
        pas_st_e st;
        logic [7:0] rdata;
        logic [3:0] pout;
    } pas_regs_s;

    pas_regs_s r;
    pas_regs_s n;
    logic tb_wrap;
    logic tb_raw;
    logic cause;
    logic sdc_wr;

    // Spread a per-pair bit to pins {d, c, b, a}
    function automatic logic [3:0] pair_mask(input logic ac,
                                             input logic bd);
        pair_mask = {bd, ac, bd, ac};
    endfunction

    // ----------------------------------------------------------------
    // Period timebase
    // ----------------------------------------------------------------
    pas_timebase u_tb (
        .clk(clk),
        .rstn(rstn),
        .run(r.en),
        .period(r.per),
        .duty(r.duty),
        .wrap(tb_wrap),
        .pwm_raw(tb_raw)
    );

    // Shutdown cause; both sources are treated as levels
    assign cause = (r.src[SDC_SRC_CMP] && cmp_shutdown)
                || (r.src[SDC_SRC_PIN] && pin_shutdown);
    assign sdc_wr = reg_wr && (reg_addr == OFS_SDC);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        n.rdata = 8'h00;
        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL: begin
                    n.pol = reg_wdata[CTRL_POL_BD:CTRL_POL_AC];
                    n.en = reg_wdata[CTRL_EN];
                end
                OFS_DBD: n.restart = reg_wdata[DBD_RESTART];
                OFS_SDC: begin
                    n.src = reg_wdata[SDC_SRC_PIN:SDC_SRC_CMP];
                    n.lvl = reg_wdata[SDC_LVL_BD:SDC_LVL_AC];
                end
                OFS_PER: n.per = reg_wdata;
                OFS_DUTY: n.duty = reg_wdata;
                OFS_OE: n.oe = reg_wdata[3:0];
                OFS_IST: n.ist = r.ist & ~reg_wdata[1:0];
                OFS_IMSK: n.imsk = reg_wdata[1:0];
                default: n.imsk = r.imsk;
            endcase
        end
        // A live cause wins over any write, so the flag cannot be cleared
        if (cause) begin
            n.flag = 1'b1;
        end else if (sdc_wr) begin
            n.flag = reg_wdata[SDC_FLAG];
        end else if (r.restart) begin
            n.flag = 1'b0;
        end else begin
            n.flag = r.flag;
        end
        // Events set status after the W1C clear so a set is never lost
        if (tb_wrap) begin
            n.ist[IRQ_PER] = 1'b1;
        end
        if (n.flag && !r.flag) begin
            n.ist[IRQ_SD] = 1'b1;
        end
        // Output sequencing
        case (r.st)
            ST_OFF: begin
                if (n.en) begin
                    n.st = n.flag ? ST_SHUT : ST_RUN;
                end
            end
            ST_RUN: begin
                if (n.flag) begin
                    n.st = ST_SHUT;
                end
            end
            ST_SHUT: begin
                if (!n.flag) begin
                    n.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (n.flag) begin
                    n.st = ST_SHUT;
                end else if (tb_wrap) begin
                    n.st = ST_RUN;
                end
            end
            default: n.st = ST_OFF;
        endcase
        if (!n.en) begin
            n.st = ST_OFF;
        end
        // Pin levels: A and D carry the waveform, B and C its complement
        case (n.st)
            ST_RUN: n.pout = {tb_raw, ~tb_raw, ~tb_raw, tb_raw}
                           ^ pair_mask(n.pol[0], n.pol[1]);
            ST_SHUT, ST_WAIT: n.pout = pair_mask(n.lvl[0],
                                                 n.lvl[1]);
            default: n.pout = pair_mask(n.pol[0], n.pol[1]);
        endcase
        // Read data stand in the cycle after the strobe only
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: n.rdata = {5'h00, r.en, r.pol};
                OFS_DBD: n.rdata = {r.restart, 7'h00};
                OFS_SDC: n.rdata = {r.flag, 3'h0, r.lvl, r.src};
                OFS_PER: n.rdata = r.per;
                OFS_DUTY: n.rdata = r.duty;
                OFS_OE: n.rdata = {4'h0, r.oe};
                OFS_IST: n.rdata = {6'h00, r.ist};
                OFS_IMSK: n.rdata = {6'h00, r.imsk};
                default: n.rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Enables clear at reset so no pin is driven before software asks
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r.pol <= POL_RST;
            r.en <= 1'b0;
            r.restart <= 1'b0;
            r.src <= SRC_RST;
            r.lvl <= LVL_RST;
            r.flag <= 1'b0;
            r.per <= PER_RST;
            r.duty <= DUTY_RST;
            r.oe <= OE_RST;
            r.ist <= IST_RST;
            r.imsk <= IMSK_RST;
            r.st <= ST_OFF;
            r.rdata <= 8'h00;
            r.pout <= 4'h0;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata = r.rdata;
    assign pwm_out_a = r.pout[0];
    assign pwm_out_b = r.pout[1];
    assign pwm_out_c = r.pout[2];
    assign pwm_out_d = r.pout[3];
    // Polarity is not gated by the enables; software must order them
    assign pwm_out_a_oe = r.oe[0];
    assign pwm_out_b_oe = r.oe[1];
    assign pwm_out_c_oe = r.oe[2];
    assign pwm_out_d_oe = r.oe[3];
    assign irq = |(r.ist & r.imsk);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_restart_clear:
        assert property (@(posedge clk) disable iff (!rstn)
            (r.flag && r.restart && !cause && !sdc_wr) |=> !r.flag)
        else $error("flag not auto-cleared with restart enabled");

    a_cause_holds:
        assert property (@(posedge clk) disable iff (!rstn)
            cause |=> r.flag)
        else $error("flag clear while shutdown cause active");

    a_flag_sticky:
        assert property (@(posedge clk) disable iff (!rstn)
            (r.flag && !r.restart && !sdc_wr) |=> r.flag)
        else $error("flag cleared without software");

    a_resume_edge:
        assert property (@(posedge clk) disable iff (!rstn)
            (r.st == ST_WAIT && !tb_wrap) |=> (r.st != ST_RUN))
        else $error("output resumed in mid period");

    a_write_ignored:
        assert property (@(posedge clk) disable iff (!rstn)
            (sdc_wr && cause && !reg_wdata[SDC_FLAG]) |=> r.flag)
        else $error("flag write accepted during shutdown");

    a_cmp_level:
        assert property (@(posedge clk) disable iff (!rstn)
            (r.src[SDC_SRC_CMP] && cmp_shutdown) [*2] |=> r.flag)
        else $error("comparator level did not hold flag");

    a_force_shut:
        assert property (@(posedge clk) disable iff (!rstn)
            (sdc_wr && reg_wdata[SDC_FLAG] && r.en)
            |=> (r.flag && r.st == ST_SHUT))
        else $error("software force did not shut down");

    a_pair_polarity:
        assert property (@(posedge clk) disable iff (!rstn)
            (r.st == ST_RUN)
            |-> ((r.pout[0] ^ r.pout[3]) == (r.pol[0] ^ r.pol[1])
                 && (r.pout[0] ^ r.pout[2])))
        else $error("pair polarity mismatch");

    a_period_flag:
        assert property (@(posedge clk) disable iff (!rstn)
            tb_wrap |=> r.ist[IRQ_PER])
        else $error("period timer flag not set at period start");

    a_pins_float:
        assert property (@(posedge clk) disable iff (!rstn)
            !$past(rstn) |-> (r.oe == 4'h0 && r.st == ST_OFF))
        else $error("pins driven after reset");

    a_shut_levels:
        assert property (@(posedge clk) disable iff (!rstn)
            (r.flag && r.en) |-> (r.pout == pair_mask(r.lvl[0],
                                                       r.lvl[1])))
        else $error("pins not at shutdown levels");

    a_wait_levels:
        assert property (@(posedge clk) disable iff (!rstn)
            (r.st == ST_WAIT) |-> (r.pout == pair_mask(r.lvl[0],
                                                        r.lvl[1])))
        else $error("pins left shutdown level before period start");

    a_force_event:
        assert property (@(posedge clk) disable iff (!rstn)
            (sdc_wr && reg_wdata[SDC_FLAG] && !r.flag)
            |=> r.ist[IRQ_SD])
        else $error("software force did not raise shutdown event");

endmodule

`default_nettype wire

// file: src/pas_pkg.sv
// Constants and types shared by the auto-shutdown PWM block
package pas_pkg;

    // ----------------------------------------------------------------
    // Register bus geometry
    // ----------------------------------------------------------------
    localparam int PAS_AW = 3;
    localparam int PAS_DW = 8;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [2:0] OFS_CTRL = 3'h0; // enhanced_control_reg
    localparam logic [2:0] OFS_DBD = 3'h1;  // dead_band_delay_reg
    localparam logic [2:0] OFS_SDC = 3'h2;  // shutdown control and flag
    localparam logic [2:0] OFS_PER = 3'h3;  // period in clocks minus one
    localparam logic [2:0] OFS_DUTY = 3'h4; // active clocks per period
    localparam logic [2:0] OFS_OE = 3'h5;   // pin output enables
    localparam logic [2:0] OFS_IST = 3'h6;  // interrupt status, W1C
    localparam logic [2:0] OFS_IMSK = 3'h7; // interrupt mask

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_POL_AC = 0;  // 1 = pair A/C active-low
    localparam int CTRL_POL_BD = 1;  // 1 = pair B/D active-low
    localparam int CTRL_EN = 2;      // module enable
    localparam int DBD_RESTART = 7;  // auto_restart_enable
    localparam int SDC_SRC_CMP = 0;  // comparator source enable
    localparam int SDC_SRC_PIN = 1;  // shutdown pin source enable
    localparam int SDC_LVL_AC = 2;   // pin level of A/C in shutdown
    localparam int SDC_LVL_BD = 3;   // pin level of B/D in shutdown
    localparam int SDC_FLAG = 7;     // shutdown_event_flag
    localparam int IRQ_PER = 0;      // period_timer_flag
    localparam int IRQ_SD = 1;       // shutdown event

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] POL_RST = 2'h0;
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic [1:0] LVL_RST = 2'h0;
    localparam logic [7:0] PER_RST = 8'hff;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [3:0] OE_RST = 4'h0;
    localparam logic [1:0] IST_RST = 2'h0;
    localparam logic [1:0] IMSK_RST = 2'h0;

    // ----------------------------------------------------------------
    // Output sequencing states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,  // module disabled, pins at inactive level
        ST_RUN = 2'b01,  // waveform on the pins
        ST_SHUT = 2'b10, // flag set, pins at shutdown level
        ST_WAIT = 2'b11  // flag clear, waiting for period start
    } pas_st_e;

endpackage

// file: src/pas_timebase.sv
// Period counter and duty compare for the auto-shutdown PWM block
`timescale 1ns/1ps
`default_nettype none

module pas_timebase import pas_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic [7:0] period,
    input wire logic [7:0] duty,
    output logic wrap,
    output logic pwm_raw
);

    typedef struct packed {
        logic [7:0] cnt;
        logic wrap;
        logic raw;
    } pas_tb_s;

    pas_tb_s r;
    pas_tb_s n;

    // Count 0..period; wrap marks the first clock of each later period
    always_comb begin
        n = r;
        n.wrap = 1'b0;
        if (!run) begin
            n.cnt = 8'h00;
        end else if (r.cnt == period) begin
            n.cnt = 8'h00;
            n.wrap = 1'b1;
        end else begin
            n.cnt = r.cnt + 8'h01;
        end
        // Duty of zero keeps the output inactive for the whole period
        n.raw = run && (n.cnt < duty);
    end

    // Sync reset; the counter restarts from zero on each enable
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign wrap = r.wrap;
    assign pwm_raw = r.raw;

endmodule

`default_nettype wire

// file: verif/pas_far_side.sv
// Model of the shutdown sources and the power switch stage
`timescale 1ns/1ps
`default_nettype none

module pas_far_side (
    input wire logic clk,
    input wire logic slow,
    input wire logic [1:0] trip,
    input wire logic [3:0] pwm_pins,
    input wire logic [3:0] pwm_oe,
    output logic cmp_shutdown,
    output logic pin_shutdown,
    output logic [3:0] pin_lvl
);
    // ------------------------------------------------------------
    // Shutdown sources
    // ------------------------------------------------------------
    logic [1:0] dly1_r = 2'h0;
    logic [1:0] dly2_r = 2'h0;

    // Two stages so the bench can pick a prompt or a lagging source
    always_ff @(posedge clk) begin
        dly1_r <= trip;
        dly2_r <= dly1_r;
    end

    // Comparator stays tripped for as long as commanded
    assign {pin_shutdown, cmp_shutdown} = slow ? dly2_r : dly1_r;

    // ------------------------------------------------------------
    // Switch stage
    // ------------------------------------------------------------
    // Undriven pins fall to the pull-down, keeping switches off
    assign pin_lvl = pwm_oe & pwm_pins;
endmodule
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the auto-shutdown PWM core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module tb import pas_pkg::*; ;
    typedef struct packed {logic [7:0] ctrl; logic [3:0] pins;} pas_row_s;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [7:0] reg_rdata;
    logic slow = 1'h0;
    logic [1:0] trip = 2'h0;
    logic cmp_shutdown, pin_shutdown, irq;
    logic pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d;
    logic a_oe, b_oe, c_oe, d_oe;
    logic [3:0] pin_lvl;
    logic [7:0] d;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    wire [3:0] pout = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};
    wire [3:0] oe = {d_oe, c_oe, b_oe, a_oe};
    // Inactive pin levels per polarity setting, module disabled
    pas_row_s rows [4] = '{'{8'h00, 4'h0}, '{8'h01, 4'h5},
                           '{8'h02, 4'ha}, '{8'h03, 4'hf}};

    always #12.5 clk = ~clk;

    pas_core pas_core_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmp_shutdown(cmp_shutdown),
        .pin_shutdown(pin_shutdown), .pwm_out_a(pwm_out_a),
        .pwm_out_a_oe(a_oe), .pwm_out_b(pwm_out_b), .pwm_out_b_oe(b_oe),
        .pwm_out_c(pwm_out_c), .pwm_out_c_oe(c_oe), .pwm_out_d(pwm_out_d),
        .pwm_out_d_oe(d_oe), .irq(irq));

    pas_far_side pas_far_side_inst (.clk(clk), .slow(slow), .trip(trip),
        .pwm_pins(pout), .pwm_oe(oe), .cmp_shutdown(cmp_shutdown),
        .pin_shutdown(pin_shutdown), .pin_lvl(pin_lvl));

    // ------------------------------------------------------------
    // Bus and closing tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    // Data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        v = reg_rdata;
    endtask

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One shutdown episode; slow sources lag two cycles, hence 6
    task automatic shut(input logic cmp, input logic rs, input logic [1:0] lv);
        logic [7:0] cfg;
        logic [3:0] shp;
        cfg = {4'h0, lv, ~cmp, cmp};
        shp = {lv, lv};
        wr(OFS_DBD, {rs, 7'h00});
        wr(OFS_SDC, cfg);
        @(posedge clk);
        trip <= {~cmp, cmp};
        repeat (6) @(posedge clk);
        #1;
        `CHK(pout, shp)
        `CHK(irq, 1'h1)
        wr(OFS_SDC, cfg);
        rd(OFS_SDC, d);
        `CHK(d[SDC_FLAG], 1'h1)
        @(posedge clk);
        trip <= 2'h0;
        repeat (6) @(posedge clk);
        rd(OFS_SDC, d);
        `CHK(d[SDC_FLAG], ~rs)
        if (!rs) begin
            wr(OFS_SDC, cfg);
            rd(OFS_SDC, d);
            `CHK(d[SDC_FLAG], 1'h0)
        end
        n = 0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (pout !== shp) n++;
        end
        `CHK(n > 0, 1'h1)
        wr(OFS_IST, 8'h02);
        @(posedge clk);
        `CHK(irq, 1'h0)
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        #1;
        `CHK(oe, 4'h0)
        `CHK(pin_lvl, 4'h0)
        `CHK(irq, 1'h0)
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], d);
            `CHK(d, (i == 3) ? PER_RST : 8'h00)
        end
        // Polarity chosen while pins are still undriven
        foreach (rows[i]) begin
            wr(OFS_CTRL, rows[i].ctrl);
            repeat (3) @(posedge clk);
            `CHK(pout, rows[i].pins)
        end
        // Start-up: enable, wait for the first period flag, then drive
        wr(OFS_PER, 8'h03);
        wr(OFS_DUTY, 8'h02);
        wr(OFS_IMSK, 8'h01);
        wr(OFS_CTRL, 8'h04);
        n = 0;
        while (irq !== 1'h1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(n >= 3 && n <= 7, 1'h1)
        `CHK(oe, 4'h0)
        wr(OFS_OE, 8'h0f);
        #1;
        `CHK(oe, 4'hf)
        `CHK(pin_lvl, pout)
        n = 0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (pout[0] === 1'h1 && pout[1] === 1'h0) n++;
        end
        `CHK(n, 4)
        // Mask the period flag, then clear it
        wr(OFS_IMSK, 8'h02);
        wr(OFS_IST, 8'h01);
        @(posedge clk);
        `CHK(irq, 1'h0)
        shut(1'h1, 1'h1, 2'h1);
        shut(1'h1, 1'h0, 2'h2);
        slow <= 1'h1;
        shut(1'h0, 1'h0, 2'h1);
        shut(1'h0, 1'h1, 2'h2);
        // Forced shutdown by software with no source active
        wr(OFS_SDC, 8'h88);
        rd(OFS_SDC, d);
        `CHK(d[SDC_FLAG], 1'h0)
        // Clear the event left by the first force so the next one counts
        wr(OFS_IST, 8'h02);
        wr(OFS_DBD, 8'h00);
        wr(OFS_SDC, 8'h88);
        repeat (2) @(posedge clk);
        `CHK(pout, 4'ha)
        `CHK(irq, 1'h1)
        wr(OFS_IMSK, 8'h00);
        @(posedge clk);
        `CHK(irq, 1'h0)
        rd(OFS_IST, d);
        `CHK(d[IRQ_SD], 1'h1)
        // Mid-run reset must release every driven pin again
        @(posedge clk);
        rstn <= 1'h0;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        #1;
        `CHK(oe, 4'h0)
        `CHK(pout, 4'h0)
        rd(OFS_SDC, d);
        `CHK(d, 8'h00)
        end_of_test();
    end

    // Watchdog: the whole run needs well under 1000 cycles
    initial begin
        repeat (4000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
